//--- design/swr_pkg.sv
// Shared constants for the sleep, wake and reset-cause block.
// Assumes a single 25 MHz clock and a 32-bit APB register port.
`default_nettype none
package swr_pkg;
  // Clock rate and documented times
  localparam int CLK_KHZ      = 25_000;
  localparam int DRT_LONG_NS  = 18_000_000;  // Crystal style reset timer
  localparam int DRT_POR_NS   = 1_125_000;   // Internal clock, power-up
  localparam int DRT_SHORT_NS = 10_000;      // Internal clock, later resets
  localparam int WDT_BASE_NS  = 18_000_000;  // Watchdog base period
  // Least times round up to whole cycles
  localparam int DRT_LONG_CYC  = (DRT_LONG_NS  / 1000 * CLK_KHZ + 999) / 1000;
  localparam int DRT_POR_CYC   = (DRT_POR_NS   / 1000 * CLK_KHZ + 999) / 1000;
  localparam int DRT_SHORT_CYC = (DRT_SHORT_NS / 1000 * CLK_KHZ + 999) / 1000;
  localparam int WDT_BASE_CYC  = (WDT_BASE_NS  / 1000 * CLK_KHZ + 999) / 1000;
  localparam int CNT_W         = 20;
  // Register byte offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS   = 8'h04;
  localparam logic [7:0] CMD_OFS    = 8'h08;
  localparam logic [7:0] PORT_OFS   = 8'h0c;
  localparam logic [7:0] CMPCFG_OFS = 8'h10;
  // Status bit positions
  localparam int ST_PD    = 3;
  localparam int ST_TO    = 4;
  localparam int ST_CWAKE = 6;
  localparam int ST_PWAKE = 7;
  localparam int ST_SLEEP = 8;
  // Control fields and reset value
  localparam int CT_PWEN  = 0;
  localparam int CT_CWEN  = 1;
  localparam int CT_PS_LO = 2;
  localparam int CT_PSA   = 5;
  localparam logic [5:0] CTRL_RST = 6'h3f;
  // Command bits
  localparam int CM_SLEEP  = 0;
  localparam int CM_CLRWDT = 1;
  // Serial programming
  localparam int PCMD_W = 6;
  localparam int PDAT_W = 14;
  localparam logic [5:0] PCMD_LOAD = 6'h02;
  localparam logic [5:0] PCMD_READ = 6'h04;
  localparam logic [5:0] PCMD_INC  = 6'h06;
  localparam int MEM_WORDS  = 1024;
  localparam int ADDR_W     = 11;
  localparam int OPEN_WORDS = 64;
  localparam int ID_WORDS   = 4;
  localparam int ID_W       = 4;
endpackage : swr_pkg
`default_nettype wire

//--- design/swr_prog_if.sv
// Carrier between the block top and its serial programming engine.
// Assumes both ends sit in the pclk domain.
`default_nettype none
interface swr_prog_if;
  import swr_pkg::*;
  logic              prog_mode;
  logic              code_protect;
  logic [ADDR_W-1:0] mem_addr;
  logic [PDAT_W-1:0] mem_rdata;
  logic [PDAT_W-1:0] mem_wdata;
  logic              mem_we;
  modport prog (output prog_mode, mem_addr, mem_wdata, mem_we,
                input  code_protect, mem_rdata);
  modport top  (input  prog_mode, mem_addr, mem_wdata, mem_we,
                output code_protect, mem_rdata);
endinterface : swr_prog_if
`default_nettype wire

//--- design/swr_prog.sv
// Serial program/verify engine: mode entry, command and data shifter, ID words.
// Assumes programming clock and data arrive synchronous to pclk.
`default_nettype none
module swr_prog
  import swr_pkg::*;
(
  input  wire logic  pclk,         // System clock
  input  wire logic  presetn,      // Async reset, active low
  input  wire logic  vpp_high,     // Master clear pin at programming level
  input  wire logic  prog_clk_in,  // Programming clock pin
  input  wire logic  prog_dat_in,  // Programming data pin, input
  output logic       prog_dat_out, // Programming data pin, output
  output logic       prog_dat_oe_n,// Data pin enable, low while driving
  swr_prog_if.prog   pif           // Memory side
);
  typedef enum logic [3:0] {
    PS_OFF = 4'b0001, PS_CMD = 4'b0010, PS_DIN = 4'b0100, PS_DOUT = 4'b1000
  } swr_pstate_t;

  swr_pstate_t       st_r, st_nxt;
  logic              vpp_r, clk_r;
  logic [3:0]        bit_r, bit_nxt;
  logic [PCMD_W-1:0] cmd_r, cmd_nxt;
  logic [PDAT_W-1:0] sh_r, sh_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [ID_W-1:0]   id_r [ID_WORDS], id_nxt [ID_WORDS];
  logic              we_r, we_nxt;
  logic              rise;
  logic              is_id;
  logic [1:0]        id_ix;

  assign rise  = prog_clk_in & ~clk_r;  // Schmitt buffering is in the pad
  assign is_id = addr_r >= ADDR_W'(MEM_WORDS) && addr_r < ADDR_W'(MEM_WORDS + ID_WORDS);
  assign id_ix = addr_r[1:0];

  // Verify read gate: IDs always, open words and the calibration word always
  function automatic logic [PDAT_W-1:0] read_word(input logic [PDAT_W-1:0] mem,
                                                  input logic cp, input logic id,
                                                  input logic [ADDR_W-1:0] a,
                                                  input logic [ID_W-1:0] idv);
    if (id) return {{(PDAT_W-ID_W){1'b1}}, idv};
    if (!cp || a < ADDR_W'(OPEN_WORDS) || a == ADDR_W'(MEM_WORDS - 1)) return mem;
    return '0;
  endfunction : read_word

  // Next state of the shifter
  always_comb begin
    st_nxt   = st_r;
    bit_nxt  = bit_r;
    cmd_nxt  = cmd_r;
    sh_nxt   = sh_r;
    addr_nxt = addr_r;
    id_nxt   = id_r;
    we_nxt   = 1'b0;
    if (!vpp_high) begin
      st_nxt = PS_OFF;
    end else if (st_r == PS_OFF) begin
      if (!vpp_r && !prog_clk_in && !prog_dat_in) begin
        st_nxt   = PS_CMD;
        bit_nxt  = '0;
        addr_nxt = '0;
      end
    end else if (rise) begin
      bit_nxt = bit_r + 4'h1;
      unique case (st_r)
        PS_CMD: begin
          cmd_nxt = {prog_dat_in, cmd_r[PCMD_W-1:1]};
          if (bit_r == 4'(PCMD_W - 1)) begin
            bit_nxt = '0;
            if (cmd_nxt == PCMD_LOAD) st_nxt = PS_DIN;
            if (cmd_nxt == PCMD_INC) addr_nxt = addr_r + ADDR_W'(1);
            if (cmd_nxt == PCMD_READ) begin
              st_nxt = PS_DOUT;
              sh_nxt = read_word(pif.mem_rdata, pif.code_protect, is_id, addr_r,
                                 id_r[id_ix]);
            end
          end
        end
        PS_DIN: begin
          sh_nxt = {prog_dat_in, sh_r[PDAT_W-1:1]};
          if (bit_r == 4'(PDAT_W - 1)) begin
            bit_nxt = '0;
            st_nxt  = PS_CMD;
            if (is_id) id_nxt[id_ix] = sh_nxt[ID_W-1:0];
            else we_nxt = 1'b1;
          end
        end
        PS_DOUT: begin
          sh_nxt = {1'b0, sh_r[PDAT_W-1:1]};
          if (bit_r == 4'(PDAT_W - 1)) begin
            bit_nxt = '0;
            st_nxt  = PS_CMD;
          end
        end
        default: st_nxt = PS_OFF;
      endcase
    end
  end

  // Shifter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= PS_OFF;
      vpp_r  <= 1'b0;
      clk_r  <= 1'b0;
      bit_r  <= '0;
      cmd_r  <= '0;
      sh_r   <= '0;
      addr_r <= '0;
      id_r   <= '{default: '1};
      we_r   <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      vpp_r  <= vpp_high;
      clk_r  <= prog_clk_in;
      bit_r  <= bit_nxt;
      cmd_r  <= cmd_nxt;
      sh_r   <= sh_nxt;
      addr_r <= addr_nxt;
      id_r   <= id_nxt;
      we_r   <= we_nxt;
    end
  end

  assign pif.prog_mode  = st_r != PS_OFF;
  assign pif.mem_addr   = addr_r;
  assign pif.mem_wdata  = sh_r;
  assign pif.mem_we     = we_r;
  assign prog_dat_out   = sh_r[0];
  assign prog_dat_oe_n  = st_r != PS_DOUT;  // Drive only while reading out
endmodule : swr_prog
`default_nettype wire

//--- design/swr_top.sv
// Sleep entry, wake-up, reset cause flags, watchdog, reset timer and APB port.
// Assumes the core halts on core_run_en low and restarts on core_reset_n.
`default_nettype none

// Contract
// - Watchdog wake from sleep leaves all four cause flags at zero.
// - Watchdog reset outside sleep clears timeout and wake flags, keeps powerdown.
// - Master clear wake sets timeout, clears powerdown and wake flags.
// - Power-up sets timeout and powerdown; sleep later clears powerdown.
// - Pin change wake sets pin wake and timeout, clears the others.
// - Comparator wake sets comparator wake and timeout, clears the others.
// - Sleep clears watchdog, sets timeout, clears powerdown, stops oscillator drive.
// - Pins hold their drive state throughout sleep.
// - Watchdog reset never pulls the master clear pin low.
// - Wake by master clear, watchdog, enabled pin change or comparator change.
// - Pin wake compares against last read snapshot; stale mismatch wakes at once.
// - Comparator wake compares against last config read; stale mismatch wakes.
// - Pin wake flag covers the four wake pins since last port access.
// - Watchdog count is cleared on every wake.
// - Verify reads open unless protected; first 64 and last word always.
// - Four ID words, program mode only, low four bits kept.
// - ID words readable whatever the protection setting.
// - Program mode uses clock pin as clock and data pin as data.
// - Six-bit command, then fourteen data bits for load or read.
// - Watchdog fuse at zero disables the watchdog completely.
// - Every wake or watchdog reset holds the core for the reset timer.
module swr_top
  import swr_pkg::*;
#(
  parameter int DRT_LONG  = DRT_LONG_CYC,  // 18 ms reset timer
  parameter int DRT_POR   = DRT_POR_CYC,   // 1.125 ms reset timer
  parameter int WDT_BASE  = WDT_BASE_CYC   // 18 ms watchdog base
) (
  input  wire logic              pclk,           // 25 MHz clock
  input  wire logic              presetn,        // Power-on reset, active low
  input  wire logic              psel,           // APB select
  input  wire logic              penable,        // APB enable
  input  wire logic              pwrite,         // APB direction
  input  wire logic [7:0]        paddr,          // APB byte address
  input  wire logic [31:0]       pwdata,         // APB write data
  output logic      [31:0]       prdata,         // APB read data
  output logic                   pready,         // APB ready
  output logic                   pslverr,        // APB error, unmapped
  input  wire logic              master_clear_pin_pin_in,    // Master clear pin level
  output logic                   master_clear_pin_pin_out,   // Master clear pin output
  output logic                   master_clear_pin_pin_oe_n,  // Master clear drive, low drives
  input  wire logic              vpp_high,       // Pin at programming voltage
  input  wire logic              master_clear_pin_enable,    // Pin configured as master clear
  input  wire logic              watchdog_enable_fuse, // Watchdog fuse
  input  wire logic              code_protect,   // Code protection fuse
  input  wire logic              drt_long_sel,   // Crystal oscillator mode
  input  wire logic [3:0]        wake_pins,      // Four wake-capable pins
  input  wire logic              port_access,    // Core file or bit op on port
  input  wire logic              comparator1_output, // Comparator 1 output
  input  wire logic              comparator2_output, // Comparator 2 output
  input  wire logic              prog_clk_in,    // Programming clock pin
  input  wire logic              prog_dat_in,    // Programming data pin input
  output logic                   prog_dat_out,   // Programming data pin output
  output logic                   prog_dat_oe_n,  // Programming data drive, low drives
  output logic      [ADDR_W-1:0] mem_addr,       // Program memory address
  input  wire logic [PDAT_W-1:0] mem_rdata,      // Program memory read word
  output logic      [PDAT_W-1:0] mem_wdata,      // Program memory write word
  output logic                   mem_we,         // Program memory write pulse
  output logic                   core_reset_n,   // Core reset, active low
  output logic                   core_run_en,    // Core may fetch
  output logic                   osc_drive_en,   // Oscillator driver on
  output logic                   io_freeze       // Hold port drive state
);
  typedef enum logic [2:0] {
    SW_RUN = 3'b001, SW_SLEEP = 3'b010, SW_HOLD = 3'b100
  } swr_state_t;

  swr_prog_if pif ();

  swr_state_t       st_r, st_nxt;
  logic             to_r, to_nxt;
  logic             pd_r, pd_nxt;
  logic             pw_r, pw_nxt;
  logic             cw_r, cw_nxt;
  logic             por_r, por_nxt;
  logic [CNT_W-1:0] drt_r, drt_nxt;
  logic [CNT_W-1:0] wb_r, wb_nxt;
  logic [6:0]       wp_r, wp_nxt;
  logic [5:0]       ctrl_r, ctrl_nxt;
  logic [3:0]       psnap_r, psnap_nxt;
  logic [1:0]       csnap_r, csnap_nxt;
  logic [31:0]      rd_r, rd_nxt;
  logic             err_r, err_nxt;
  logic             wr_acc, rd_acc, setup;
  logic             cmd_sleep, cmd_clrwdt;
  logic             master_clear_pin_act, wdt_on, wdt_clr, wdt_tick, wdt_to;
  logic             pin_diff, cmp_diff;
  logic [CNT_W-1:0] drt_load;

  // Postscaler terminal count for 1:1 up to 1:128
  function automatic logic [6:0] post_limit(input logic psa, input logic [2:0] ps);
    if (!psa) return 7'h00;
    return 7'((8'h01 << ps) - 8'h01);
  endfunction : post_limit

  // Reset timer length, long for crystal modes, short after power-up
  function automatic logic [CNT_W-1:0] drt_len(input logic lng, input logic por);
    if (lng) return CNT_W'(DRT_LONG);
    if (por) return CNT_W'(DRT_POR);
    return CNT_W'(DRT_SHORT_CYC);
  endfunction : drt_len

  // Known register offsets answer, anything else flags an error
  function automatic logic mapped(input logic [7:0] a);
    return a == STATUS_OFS || a == CTRL_OFS || a == CMD_OFS
        || a == PORT_OFS || a == CMPCFG_OFS;
  endfunction : mapped

  // APB phase decode; every access finishes in its first access cycle
  assign setup      = psel & ~penable;
  assign wr_acc     = psel & penable & pwrite;
  assign rd_acc     = psel & penable & ~pwrite;
  assign cmd_sleep  = wr_acc && paddr == CMD_OFS && pwdata[CM_SLEEP];
  assign cmd_clrwdt = wr_acc && paddr == CMD_OFS && pwdata[CM_CLRWDT];
  assign pready     = psel & penable;
  assign pslverr    = err_r & psel & penable;
  assign prdata     = rd_r;

  // Master clear counts only when the pin is so configured and not at Vpp
  assign master_clear_pin_act = master_clear_pin_enable & ~master_clear_pin_pin_in & ~vpp_high;

  // Wake comparisons run against snapshots, so stale mismatches wake at once
  assign pin_diff = ctrl_r[CT_PWEN] && wake_pins != psnap_r;
  assign cmp_diff = ctrl_r[CT_CWEN]
                 && {comparator2_output, comparator1_output} != csnap_r;

  // Watchdog runs in run and sleep only while the fuse allows it
  assign wdt_on   = watchdog_enable_fuse && st_r != SW_HOLD;
  assign wdt_tick = wb_r == CNT_W'(WDT_BASE - 1);
  assign wdt_to   = wdt_on && wdt_tick
                 && wp_r == post_limit(ctrl_r[CT_PSA], ctrl_r[CT_PS_LO +: 3]);
  assign drt_load = drt_len(drt_long_sel, por_r);

  // Reset cause and sleep sequencing
  always_comb begin
    st_nxt  = st_r;
    to_nxt  = to_r;
    pd_nxt  = pd_r;
    pw_nxt  = pw_r;
    cw_nxt  = cw_r;
    por_nxt = por_r;
    drt_nxt = drt_r;
    wdt_clr = cmd_clrwdt;
    unique case (st_r)
      SW_RUN: begin
        if (master_clear_pin_act) begin
          st_nxt = SW_HOLD;
          pw_nxt = 1'b0;
          cw_nxt = 1'b0;
        end else if (wdt_to) begin
          st_nxt = SW_HOLD;
          to_nxt = 1'b0;
          pw_nxt = 1'b0;
          cw_nxt = 1'b0;
        end else if (cmd_sleep) begin
          st_nxt  = SW_SLEEP;
          to_nxt  = 1'b1;
          pd_nxt  = 1'b0;
          wdt_clr = 1'b1;
        end
        drt_nxt = drt_load;
      end
      SW_SLEEP: begin
        // Wake priority: master clear, watchdog, pins, comparators
        if (master_clear_pin_act || wdt_to || pin_diff || cmp_diff) begin
          st_nxt  = SW_HOLD;
          wdt_clr = 1'b1;
          pd_nxt  = 1'b0;
          to_nxt  = !(wdt_to && !master_clear_pin_act);
          pw_nxt  = !master_clear_pin_act && !wdt_to && pin_diff;
          cw_nxt  = !master_clear_pin_act && !wdt_to && !pin_diff;
        end
        drt_nxt = drt_load;
      end
      SW_HOLD: begin
        // Timer restarts while master clear stays low
        if (master_clear_pin_act) begin
          drt_nxt = drt_load;
        end else if (drt_r <= CNT_W'(1)) begin
          st_nxt  = SW_RUN;
          por_nxt = 1'b0;
        end else begin
          drt_nxt = drt_r - CNT_W'(1);
        end
      end
      default: st_nxt = SW_HOLD;
    endcase
  end

  // Cause flags power up with timeout and powerdown set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= SW_HOLD;
      to_r  <= 1'b1;
      pd_r  <= 1'b1;
      pw_r  <= 1'b0;
      cw_r  <= 1'b0;
      por_r <= 1'b1;
      drt_r <= CNT_W'(DRT_LONG);
    end else begin
      st_r  <= st_nxt;
      to_r  <= to_nxt;
      pd_r  <= pd_nxt;
      pw_r  <= pw_nxt;
      cw_r  <= cw_nxt;
      por_r <= por_nxt;
      drt_r <= drt_nxt;
    end
  end

  // Watchdog base counter and postscaler
  always_comb begin
    wb_nxt = wb_r;
    wp_nxt = wp_r;
    if (!wdt_on || wdt_clr || wdt_to) begin
      wb_nxt = '0;
      wp_nxt = '0;
    end else if (wdt_tick) begin
      wb_nxt = '0;
      wp_nxt = wp_r + 7'h01;
    end else begin
      wb_nxt = wb_r + CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_r <= '0;
      wp_r <= '0;
    end else begin
      wb_r <= wb_nxt;
      wp_r <= wp_nxt;
    end
  end

  // Register file; read data is latched in the setup cycle
  always_comb begin
    ctrl_nxt  = ctrl_r;
    psnap_nxt = psnap_r;
    csnap_nxt = csnap_r;
    rd_nxt    = rd_r;
    err_nxt   = err_r;
    if (wr_acc && paddr == CTRL_OFS) ctrl_nxt = pwdata[5:0];
    // Port read or core port access refreshes the pin snapshot
    if ((rd_acc && paddr == PORT_OFS) || port_access) psnap_nxt = wake_pins;
    if (rd_acc && paddr == CMPCFG_OFS)
      csnap_nxt = {comparator2_output, comparator1_output};
    if (setup) begin
      err_nxt = !mapped(paddr);
      rd_nxt  = '0;
      unique case (paddr)
        STATUS_OFS: begin
          rd_nxt[ST_PD]    = pd_r;
          rd_nxt[ST_TO]    = to_r;
          rd_nxt[ST_CWAKE] = cw_r;
          rd_nxt[ST_PWAKE] = pw_r;
          rd_nxt[ST_SLEEP] = st_r == SW_SLEEP;
        end
        CTRL_OFS:   rd_nxt[5:0] = ctrl_r;
        PORT_OFS:   rd_nxt[3:0] = wake_pins;
        CMPCFG_OFS: rd_nxt[1:0] = {comparator2_output, comparator1_output};
        default:    rd_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= CTRL_RST;
      psnap_r <= '0;
      csnap_r <= '0;
      rd_r    <= '0;
      err_r   <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      psnap_r <= psnap_nxt;
      csnap_r <= csnap_nxt;
      rd_r    <= rd_nxt;
      err_r   <= err_nxt;
    end
  end

  // Program/verify engine shares the memory port with nothing else
  swr_prog u_prog (
    .pclk          (pclk),
    .presetn       (presetn),
    .vpp_high      (vpp_high),
    .prog_clk_in   (prog_clk_in),
    .prog_dat_in   (prog_dat_in),
    .prog_dat_out  (prog_dat_out),
    .prog_dat_oe_n (prog_dat_oe_n),
    .pif           (pif.prog)
  );

  assign pif.code_protect = code_protect;
  assign pif.mem_rdata    = mem_rdata;
  assign mem_addr         = pif.mem_addr;
  assign mem_wdata        = pif.mem_wdata;
  assign mem_we           = pif.mem_we;

  // Core control; program mode keeps the core in reset
  assign core_reset_n  = st_r != SW_HOLD && !pif.prog_mode;
  assign core_run_en   = st_r == SW_RUN && !pif.prog_mode;
  assign osc_drive_en  = st_r != SW_SLEEP;
  assign io_freeze     = st_r == SW_SLEEP;
  // Reset is internal only; the pin is never driven
  assign master_clear_pin_pin_out  = 1'b0;
  assign master_clear_pin_pin_oe_n = 1'b1;
endmodule : swr_top
`default_nettype wire

//--- testbench/swr_mem.sv
// Program memory model on the far side of the programming engine.
// Assumes the engine reads combinationally from the word address.
`default_nettype none
module swr_mem
  import swr_pkg::*;
(
  input  wire logic [ADDR_W-1:0] mem_addr,  // Word address
  output logic      [PDAT_W-1:0] mem_rdata  // Word at that address
);
  timeunit 1ns;
  timeprecision 1ps;
  // Address-derived words, so neighbours never read alike
  assign mem_rdata = {3'h5, mem_addr};
endmodule : swr_mem
`default_nettype wire

//--- testbench/swr_top_asserts.sv
// Checker for sleep entry, wake hold, pin drive and APB answers.
// Assumes it is bound to swr_top and sees only its ports.
`default_nettype none
module swr_top_asserts
  import swr_pkg::*;
(
  input wire logic       pclk,          // Clock
  input wire logic       presetn,       // Reset, active low
  input wire logic       psel,          // APB select
  input wire logic       penable,       // APB enable
  input wire logic       pwrite,        // APB direction
  input wire logic [7:0] paddr,         // APB address
  input wire logic       pready,        // APB ready
  input wire logic       pslverr,       // APB error
  input wire logic       master_clear_pin_pin_oe_n, // Pin drive, low drives
  input wire logic       core_reset_n,  // Core reset
  input wire logic       core_run_en,   // Core fetch enable
  input wire logic       osc_drive_en,  // Oscillator drive
  input wire logic       io_freeze      // Port hold
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cmd_wr;
  // Command write in its access cycle
  assign cmd_wr = psel && penable && pwrite && (paddr == CMD_OFS);
  // One domain, so shared clock and disable
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_nodrive; master_clear_pin_pin_oe_n; endproperty
  a_nodrive: assert property (p_nodrive) else $error("pin driven");
  property p_osc; io_freeze == !osc_drive_en; endproperty
  a_osc: assert property (p_osc) else $error("osc drive in sleep");
  property p_enter; $rose(io_freeze) |-> $past(cmd_wr); endproperty
  a_enter: assert property (p_enter) else $error("sleep without command");
  property p_halt; io_freeze |-> !core_run_en; endproperty
  a_halt: assert property (p_halt) else $error("fetch in sleep");
  property p_run; core_run_en |-> core_reset_n; endproperty
  a_run: assert property (p_run) else $error("fetch in reset");
  property p_wake; $fell(io_freeze) |-> !core_reset_n; endproperty
  a_wake: assert property (p_wake) else $error("wake without reset");
  property p_drt; $fell(core_reset_n) |-> !core_reset_n[*8]; endproperty
  a_drt: assert property (p_drt) else $error("reset timer short");
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("stray error");
  c_sleep: cover property ($rose(io_freeze));
  c_wake: cover property ($fell(io_freeze));
  c_err: cover property (pslverr);
endmodule : swr_top_asserts
bind swr_top swr_top_asserts u_chk (.*);
`default_nettype wire

//--- testbench/test_swr_top.sv
// Bench for swr_top: cause flags, sleep entry, wake sources, APB errors.
// Assumes small reset timer and watchdog counts given as parameters.
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module test_swr_top
  import swr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        master_clear_pin_pin_in = 1, vpp_high = 0, watchdog_enable_fuse = 0, port_access = 0;
  logic        master_clear_pin_enable = 1, code_protect = 0, drt_long_sel = 0, comparator1_output = 0;
  logic        prog_clk_in = 0, prog_dat_in = 0, comparator2_output = 0;
  logic        pready, pslverr, master_clear_pin_pin_out, master_clear_pin_pin_oe_n, prog_dat_out, prog_dat_oe_n;
  logic        mem_we, core_reset_n, core_run_en, osc_drive_en, io_freeze;
  logic [3:0]  wake_pins = 4'h0;
  logic [ADDR_W-1:0] mem_addr;
  logic [PDAT_W-1:0] mem_rdata, mem_wdata;
  int          failures = 0, comparisons = 0;
  swr_top #(.DRT_LONG(40), .DRT_POR(20), .WDT_BASE(30)) uut (.*);
  swr_mem u_mem (.*);
  // 25 MHz clock
  initial forever #20 pclk = ~pclk;
  task automatic give_verdict;
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // One transfer plus an idle edge, so back-to-back calls never collide
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Flags as {pin wake, comparator wake, timeout, powerdown}
  task automatic st(input logic [3:0] e);
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK("status", e, {rd[ST_PWAKE], rd[ST_CWAKE], rd[ST_TO], rd[ST_PD]})
  endtask : st
  // Bounded wait on the core reset level
  task automatic wait_rst(input logic lvl);
    for (int i = 0; i < 6000 && core_reset_n !== lvl; i++) @(posedge pclk);
  endtask : wait_rst
  // One programming bit: clock low edge (output sampled, settled), then the rising edge
  task automatic pbit(input logic b, output logic o);
    prog_dat_in <= b;
    prog_clk_in <= 1'b0;
    @(posedge pclk);
    o = prog_dat_out;
    prog_clk_in <= 1'b1;
    @(posedge pclk);
  endtask : pbit
  task automatic wake;
    wait_rst(1'b0);
    master_clear_pin_pin_in <= 1'b1;
    wait_rst(1'b1);
  endtask : wake
  // Refresh both snapshots first, else a stale mismatch wakes at once
  task automatic go_sleep(input logic [31:0] c);
    port_access <= 1'b1;
    @(posedge pclk);
    port_access <= 1'b0;
    apb(1'b0, CMPCFG_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, c);
    apb(1'b1, CMD_OFS, 32'h1);
    `CHK("freeze", 1'b1, io_freeze)
    `CHK("osc", 1'b0, osc_drive_en)
  endtask : go_sleep
  task automatic t_por;
    wait_rst(1'b1);
    st(4'b0011);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0, rd)
  endtask : t_por
  task automatic t_resets;
    watchdog_enable_fuse <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h0);
    wake();
    st(4'b0001);
    master_clear_pin_pin_in <= 1'b0;
    wake();
    st(4'b0001);
    go_sleep(32'h0);
    wake();
    st(4'b0000);
    watchdog_enable_fuse <= 1'b0;
  endtask : t_resets
  task automatic t_pin;
    go_sleep(32'h1);
    wake_pins <= 4'h5;
    wake();
    st(4'b1010);
    apb(1'b1, CMD_OFS, 32'h1);
    repeat (3) @(posedge pclk);
    `CHK("stale wake", 1'b0, io_freeze)
    wake();
  endtask : t_pin
  task automatic t_cmp_master_clear_pin;
    logic [PDAT_W-1:0] w;
    logic              o;
    go_sleep(32'h2);
    {comparator1_output, comparator2_output} <= 2'b11;
    wake();
    st(4'b0110);
    go_sleep(32'h0);
    repeat (100) @(posedge pclk);
    `CHK("fuse off", 1'b1, io_freeze)
    master_clear_pin_pin_in <= 1'b0;
    wake();
    st(4'b0010);
    vpp_high <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("prog hold", 2'b00, {core_reset_n, core_run_en})
    // Read word 0 under protection: an open word, so the model's word comes back
    code_protect <= 1'b1;
    for (int i = 0; i < PCMD_W; i++) pbit(PCMD_READ[i], o);
    @(posedge pclk);
    `CHK("data drive", 1'b0, prog_dat_oe_n)
    for (int i = 0; i < PDAT_W; i++) pbit(1'b0, w[i]);
    `CHK("verify word", 14'h2800, w)
    vpp_high <= 1'b0;
    wait_rst(1'b1);
  endtask : t_cmp_master_clear_pin
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_por();
    t_resets();
    t_pin();
    t_cmp_master_clear_pin();
    give_verdict();
  end
  // Hang guard at 10,000 cycles, well past the expected few thousand
  initial begin
    #400_000;
    failures++;
    give_verdict();
  end
endmodule : test_swr_top
`default_nettype wire
